// file: hdl/two_wire_register_slave.sv
// Two-wire register slave: 256 x 16-bit registers, auto-increment
// Functional notes
// R1: Slave only; master alone drives clock
// R2: First byte: seven-bit address plus direction LSB
// R3: Acknowledge own slave address
// R4: Write: pointer byte follows, acknowledged
// R5: 16-bit registers as two acknowledged bytes
// R6: Register updates only after both bytes
// R7: Pointer increments after each written word
// R8: Master ends write with start or stop
// R9: Read: set pointer, repeated start, read address
// R10: Read bytes supplied singly, master acknowledges
// R11: Pointer advances after every 16 read bits
// R12: Master not-acknowledge ends read; release data
// R13: Both lines high means bus idle
// R14: Start: data falls while clock high
// R15: Stop: data rises while clock high
// R16: Only master makes start and stop
// R17: Data changes only while clock low
// R18: Transmitter releases, receiver pulls low for acknowledge
// R19: Data line only pulled low or released
// R20: MSB first, upper byte first
// R21: Foreign address ignored until next start
// R22: Asynchronous active-low reset restores defaults
`timescale 1ns/1ps
module two_wire_register_slave
	import two_wire_pkg::*;
#(
	parameter logic [ADDR_W-1:0] SLAVE_ADDR = DEV_ADDR_DEFAULT
) (
	input  wire logic              link_clk_i,
	input  wire logic              reset_n_i,
	tw_if.dev                      bus,
	output logic                   reg_wr_o,
	output logic [PTR_W-1:0]       reg_waddr_o,
	output logic [WORD_W-1:0]      reg_wdata_o,
	input  wire logic [PTR_W-1:0]  peek_addr_i,
	output logic [WORD_W-1:0]      peek_data_o
);
	typedef enum logic [3:0] {
		S_IDLE,
		S_ADDR,
		S_ACK_ADDR,
		S_PTR,
		S_ACK_PTR,
		S_WDATA,
		S_ACK_W,
		S_RDATA,
		S_RACK,
		S_IGNORE
	} dev_st_t;

	typedef struct packed {
		dev_st_t             st;
		logic                scl_p;
		logic                sda_p;
		logic [3:0]          cnt;
		logic [BYTE_W-1:0]   sh;
		logic [BYTE_W-1:0]   hi;
		logic [PTR_W-1:0]    ptr;
		logic                lo;
		logic                rw;
		logic                nack;
		logic                pull;
		logic                wr;
		logic [PTR_W-1:0]    waddr;
		logic [WORD_W-1:0]   wdata;
		logic [WORD_W-1:0]   peek;
	} dev_state_t;

	dev_state_t q;
	dev_state_t d;
	logic [WORD_W-1:0] mem [2**PTR_W];

	logic              scl;
	logic              sda;
	logic              rise;
	logic              fall;
	logic              start;
	logic              stop;
	logic [PTR_W-1:0]  ptr_nx;
	logic [WORD_W-1:0] cur;
	logic [WORD_W-1:0] nxt;

	two_wire_sync3 #(
		.INIT      (1'h1)
	) u_scl_sync (
		.clk_i     (link_clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (bus.serial_clk),
		.level_o   (scl)
	);

	two_wire_sync3 #(
		.INIT      (1'h1)
	) u_sda_sync (
		.clk_i     (link_clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (bus.serial_bus_data_pin),
		.level_o   (sda)
	);

	assign rise   = scl & ~q.scl_p;
	assign fall   = ~scl & q.scl_p;
	assign start  = scl & q.scl_p & q.sda_p & ~sda; // R14
	assign stop   = scl & q.scl_p & ~q.sda_p & sda; // R15
	assign ptr_nx = q.ptr + PTR_STEP;
	assign cur    = mem[q.ptr];
	assign nxt    = mem[ptr_nx];

	always_comb begin
		d = q;
		d.wr = 1'h0;
		d.scl_p = scl;
		d.sda_p = sda;
		d.peek = mem[peek_addr_i];
		if (start) begin
			// Also a repeated start; pointer kept for reads
			d.st = S_ADDR; // R8 R9 R21
			d.cnt = '0;
			d.pull = 1'h0;
		end else if (stop) begin
			d.st = S_IDLE; // R8 R13
			d.pull = 1'h0;
		end else begin
			case (q.st)
			S_IDLE, S_IGNORE: begin
				d.pull = 1'h0; // R13 R21
			end
			S_ADDR, S_PTR, S_WDATA: begin
				if (rise) begin
					// Sample on rising clock, MSB first
					d.sh = {q.sh[BYTE_W-2:0], sda}; // R17 R20
					d.cnt = q.cnt + ONE_BIT;
				end else if (fall && q.cnt == BYTE_BITS) begin
					d.cnt = '0;
					d.pull = 1'h1; // R18
					case (q.st)
					S_ADDR: begin
						if (q.sh[BYTE_W-1:1] != SLAVE_ADDR) begin
							d.st = S_IGNORE; // R21
							d.pull = 1'h0;
						end else begin
							d.rw = q.sh[0]; // R2
							d.st = S_ACK_ADDR; // R3
						end
					end
					S_PTR: begin
						d.ptr = q.sh; // R4
						d.lo = 1'h0;
						d.st = S_ACK_PTR;
					end
					default: begin
						d.st = S_ACK_W; // R5
						if (q.lo) begin
							d.wr = 1'h1; // R6
							d.waddr = q.ptr;
							d.wdata = {q.hi, q.sh}; // R20
							d.ptr = ptr_nx; // R7
							d.lo = 1'h0;
						end else begin
							d.hi = q.sh; // R6
							d.lo = 1'h1;
						end
					end
					endcase
				end
			end
			S_ACK_ADDR, S_ACK_PTR, S_ACK_W: begin
				if (fall) begin
					d.pull = 1'h0; // R18
					d.cnt = '0;
					if (q.st == S_ACK_ADDR && q.rw == DIR_READ) begin
						d.st = S_RDATA; // R9
						d.lo = 1'h0;
						d.sh = cur[WORD_W-1 -: BYTE_W]; // R20
						d.pull = ~cur[WORD_W-1]; // R17 R19
					end else if (q.st == S_ACK_ADDR) begin
						d.st = S_PTR; // R4
					end else begin
						d.st = S_WDATA;
					end
				end
			end
			S_RDATA: begin
				if (fall) begin
					if (q.cnt == LAST_BIT) begin
						d.st = S_RACK;
						d.pull = 1'h0; // R18
						d.cnt = '0;
					end else begin
						d.sh = q.sh << 1;
						d.pull = ~q.sh[BYTE_W-2]; // R10 R17
						d.cnt = q.cnt + ONE_BIT;
					end
				end
			end
			S_RACK: begin
				if (rise) begin
					d.nack = sda; // R12
				end else if (fall) begin
					if (q.nack) begin
						d.st = S_IGNORE; // R12
						d.ptr = q.lo ? ptr_nx : q.ptr; // R11
					end else if (!q.lo) begin
						d.st = S_RDATA; // R10
						d.sh = cur[BYTE_W-1:0];
						d.lo = 1'h1;
						d.pull = ~cur[BYTE_W-1];
					end else begin
						d.st = S_RDATA;
						d.ptr = ptr_nx; // R11
						d.sh = nxt[WORD_W-1 -: BYTE_W];
						d.lo = 1'h0;
						d.pull = ~nxt[WORD_W-1];
					end
				end
			end
			default: begin
				d.st = S_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '{st: S_IDLE, scl_p: 1'h1, sda_p: 1'h1, // R22
				ptr: PTR_RESET, default: '0};
		end else begin
			q <= d;
		end
	end

	// Register array, written one cycle after the second byte lands
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 2**PTR_W; i++) begin
				mem[i] <= REG_RESET; // R22
			end
		end else if (q.wr) begin
			mem[q.waddr] <= q.wdata; // R6
		end
	end

	// Never drives high, never clocks the line
	assign bus.dev_data_out  = 1'h0; // R1 R16 R19
	assign bus.dev_data_oe_n = ~q.pull; // R19
	assign reg_wr_o          = q.wr;
	assign reg_waddr_o       = q.waddr;
	assign reg_wdata_o       = q.wdata;
	assign peek_data_o       = q.peek;
endmodule // two_wire_register_slave

// file: hdl/two_wire_pkg.sv
// Shared constants for the two-wire register slave and its bus master
package two_wire_pkg;
	localparam int          BYTE_W        = 8;
	localparam int          WORD_W        = 16;
	localparam int          PTR_W         = 8;
	localparam int          ADDR_W        = 7;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [3:0]  LAST_BIT      = 4'h7;
	localparam logic [3:0]  ONE_BIT       = 4'h1;
	localparam logic        DIR_WRITE     = 1'h0;
	localparam logic        DIR_READ      = 1'h1;
	// Bus address of the slave; value is arbitrary
	localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h5D;
	localparam logic [15:0] REG_RESET     = 16'h0000;
	localparam logic [7:0]  PTR_RESET     = 8'h00;
	localparam logic [7:0]  PTR_STEP      = 8'h01;
	// Host timing: serial clock derived from clk_i
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          SCL_PERIOD_NS = 10000;
	// Least quarter period, rounded up to whole cycles
	localparam int          QTR_CYCLES_DEFAULT =
		(SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host transaction steps
	localparam logic [2:0]  STP_START     = 3'h0;
	localparam logic [2:0]  STP_ADDR_W    = 3'h1;
	localparam logic [2:0]  STP_PTR       = 3'h2;
	localparam logic [2:0]  STP_WR_HI     = 3'h3;
	localparam logic [2:0]  STP_WR_LO     = 3'h4;
	localparam logic [2:0]  STP_WR_STOP   = 3'h5;
	localparam logic [2:0]  STP_RESTART   = 3'h3;
	localparam logic [2:0]  STP_ADDR_R    = 3'h4;
	localparam logic [2:0]  STP_RX_HI     = 3'h5;
	localparam logic [2:0]  STP_RX_LO     = 3'h6;
	localparam logic [2:0]  STP_RD_STOP   = 3'h7;
	localparam logic [2:0]  STP_ONE       = 3'h1;
	localparam logic [1:0]  Q_DRIVE       = 2'h0;
	localparam logic [1:0]  Q_RISE        = 2'h1;
	localparam logic [1:0]  Q_SAMPLE      = 2'h2;
	localparam logic [1:0]  Q_FALL        = 2'h3;
	localparam logic [1:0]  Q_ONE         = 2'h1;
	localparam logic [15:0] DIV_ONE       = 16'h0001;
endpackage

// file: hdl/tw_if.sv
// Two-wire link between bus master and register slave
`timescale 1ns/1ps
interface tw_if;
	logic serial_clk;
	logic host_data_out;
	logic host_data_oe_n;
	logic dev_data_out;
	logic dev_data_oe_n;
	logic serial_bus_data_pin;

	// Open-drain line with pull-up: low if any enabled driver pulls low
	assign serial_bus_data_pin = (host_data_oe_n | host_data_out)
		& (dev_data_oe_n | dev_data_out);

	modport host (
		output serial_clk,
		output host_data_out,
		output host_data_oe_n,
		input  serial_bus_data_pin
	);
	modport dev (
		input  serial_clk,
		input  serial_bus_data_pin,
		output dev_data_out,
		output dev_data_oe_n
	);
endinterface // tw_if

// file: hdl/two_wire_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module two_wire_sync3 #(
	parameter logic INIT = 1'h1
) (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic async_i,
	output logic      level_o
);
	typedef struct packed {
		logic [2:0] ff;
		logic       lvl;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.ff = {s_q.ff[1:0], async_i};
		// Stage 0 feeds only stage 1; filter looks at stages 1 and 2
		if (s_q.ff[1] == s_q.ff[2]) begin
			s_d.lvl = s_q.ff[2];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= {{3{INIT}}, INIT};
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.lvl;
endmodule // two_wire_sync3

// file: hdl/two_wire_bus_master.sv
// Two-wire bus master: single-word register write or read
`timescale 1ns/1ps
module two_wire_bus_master
	import two_wire_pkg::*;
#(
	parameter logic [ADDR_W-1:0] TARGET_ADDR = DEV_ADDR_DEFAULT,
	parameter int                QTR_CYCLES  = QTR_CYCLES_DEFAULT
) (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	tw_if.host                     bus,
	input  wire logic              cmd_valid_i,
	output logic                   cmd_ready_o,
	input  wire logic              cmd_read_i,
	input  wire logic [PTR_W-1:0]  cmd_ptr_i,
	input  wire logic [WORD_W-1:0] cmd_wdata_i,
	output logic                   rsp_valid_o,
	output logic [WORD_W-1:0]      rsp_data_o,
	output logic                   rsp_nack_o
);
	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} host_st_t;

	typedef struct packed {
		host_st_t           st;
		logic [15:0]        div;
		logic [1:0]         qtr;
		logic [2:0]         step;
		logic [3:0]         bitn;
		logic               rd;
		logic [BYTE_W-1:0]  tx;
		logic [WORD_W-1:0]  rx;
		logic               nack;
		logic               scl;
		logic               rel;
		logic [PTR_W-1:0]   ptr;
		logic [WORD_W-1:0]  wdata;
		logic               rvalid;
		logic [WORD_W-1:0]  rdata;
		logic               rnack;
	} host_state_t;

	localparam logic [15:0] DIV_LAST = 16'(QTR_CYCLES - 1);

	host_state_t q;
	host_state_t d;
	logic        sda;
	logic        tick;
	logic [2:0]  step_nx;
	logic        is_rx;

	two_wire_sync3 #(
		.INIT      (1'h1)
	) u_sda_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (bus.serial_bus_data_pin),
		.level_o   (sda)
	);

	assign tick    = (q.div == DIV_LAST);
	assign step_nx = q.step + STP_ONE;
	assign is_rx   = q.rd && (q.step == STP_RX_HI || q.step == STP_RX_LO);

	always_comb begin
		d = q;
		d.rvalid = 1'h0;
		if (q.st == H_IDLE) begin
			d.scl = 1'h1;
			d.rel = 1'h1;
			if (cmd_valid_i) begin
				d.st = H_START;
				d.rd = cmd_read_i;
				d.ptr = cmd_ptr_i;
				d.wdata = cmd_wdata_i;
				d.step = STP_START;
				d.qtr = Q_DRIVE;
				d.div = '0;
				d.nack = 1'h0;
				d.rx = '0;
			end
		end else if (!tick) begin
			d.div = q.div + DIV_ONE;
		end else begin
			d.div = '0;
			d.qtr = q.qtr + Q_ONE;
			case (q.qtr)
			Q_DRIVE: begin
				d.scl = 1'h0;
				if (q.st == H_START) begin
					d.rel = 1'h1;
				end else if (q.st == H_STOP) begin
					d.rel = 1'h0;
				end else if (q.bitn != BYTE_BITS) begin
					d.rel = is_rx ? 1'h1 : q.tx[BYTE_W-1]; // R17 R18 R20
				end else begin
					// Acknowledge the high byte, refuse the last
					d.rel = is_rx ? (q.step == STP_RX_LO) : 1'h1; // R10 R12
				end
			end
			Q_RISE: begin
				d.scl = 1'h1;
			end
			Q_SAMPLE: begin
				if (q.st == H_START) begin
					d.rel = 1'h0; // R14 R16
				end else if (q.st == H_STOP) begin
					d.rel = 1'h1; // R15 R16
				end else if (q.bitn != BYTE_BITS) begin
					if (is_rx) begin
						d.rx = {q.rx[WORD_W-2:0], sda}; // R20
					end
				end else if (!is_rx) begin
					d.nack = sda; // R3 R4 R5
				end
			end
			default: begin
				if (q.st == H_STOP) begin
					d.st = H_IDLE;
					d.rvalid = 1'h1;
					d.rdata = q.rx;
					d.rnack = q.nack;
				end else begin
					d.scl = 1'h0;
					if (q.st == H_BIT && q.bitn != BYTE_BITS) begin
						d.tx = q.tx << 1;
						d.bitn = q.bitn + ONE_BIT;
					end else if (q.nack) begin
						d.st = H_STOP; // R8
					end else begin
						d.step = step_nx;
						d.bitn = '0;
						d.st = H_BIT;
						if (q.rd && step_nx == STP_RESTART) begin
							d.st = H_START; // R9
						end
						if ((q.rd && step_nx == STP_RD_STOP)
							|| (!q.rd && step_nx == STP_WR_STOP)) begin
							d.st = H_STOP;
						end
						case (step_nx)
						STP_ADDR_W: d.tx = {TARGET_ADDR, DIR_WRITE}; // R2
						STP_PTR:    d.tx = q.ptr;
						STP_WR_HI:  d.tx = q.wdata[WORD_W-1 -: BYTE_W];
						STP_WR_LO:  d.tx = q.rd ? {TARGET_ADDR, DIR_READ}
							: q.wdata[BYTE_W-1:0];
						default:    d.tx = '0;
						endcase
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '{st: H_IDLE, scl: 1'h1, rel: 1'h1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign bus.serial_clk     = q.scl; // R1
	assign bus.host_data_out  = 1'h0; // R19
	assign bus.host_data_oe_n = q.rel;
	assign cmd_ready_o        = (q.st == H_IDLE);
	assign rsp_valid_o        = q.rvalid;
	assign rsp_data_o         = q.rdata;
	assign rsp_nack_o         = q.rnack;
endmodule // two_wire_bus_master

// file: dv/two_wire_register_slave_assertions.sv
// Protocol checker for the two-wire link between master and slave
`timescale 1ns/1ps
module two_wire_register_slave_assertions #(
	parameter int QTR_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic link_clk_i,
	input wire logic reset_n_i,
	input wire logic serial_clk,
	input wire logic host_data_out,
	input wire logic host_data_oe_n,
	input wire logic dev_data_out,
	input wire logic dev_data_oe_n,
	input wire logic serial_bus_data_pin
);
	localparam int START_MAX = QTR_CYCLES + 1;
	localparam int LOW_MAX   = 2 * QTR_CYCLES;

	sequence start_seq;
		$fell(host_data_oe_n) && serial_clk;
	endsequence
	sequence stop_seq;
		$rose(host_data_oe_n) && serial_clk;
	endsequence

	chk_host_open_drain: assert property (@(posedge clk_i)
		disable iff (!reset_n_i) host_data_out == 1'h0
		&& serial_bus_data_pin == (host_data_oe_n && dev_data_oe_n))
		else $error("data line not open drain");
	chk_dev_open_drain: assert property (@(posedge link_clk_i)
		disable iff (!reset_n_i) dev_data_out == 1'h0)
		else $error("slave drives data high");
	chk_dev_change_low: assert property (@(posedge link_clk_i)
		disable iff (!reset_n_i) $changed(dev_data_oe_n)
		|-> !serial_clk && !$past(serial_clk))
		else $error("slave data moved while clock high");
	chk_start_shape: assert property (@(posedge clk_i)
		disable iff (!reset_n_i) start_seq |-> ##[1:START_MAX] !serial_clk)
		else $error("clock did not fall after start");
	chk_stop_idle: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		stop_seq |-> (serial_clk && serial_bus_data_pin)[*8])
		else $error("bus not idle after stop");
	chk_scl_low_phase: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		$fell(serial_clk) |-> (!serial_clk)[*8] ##[1:LOW_MAX] serial_clk)
		else $error("serial clock low phase wrong");
	chk_no_contention: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		serial_clk && !dev_data_oe_n |-> host_data_oe_n)
		else $error("both ends drive while clock high");
	chk_stop_release: assert property (@(posedge link_clk_i)
		disable iff (!reset_n_i)
		$rose(serial_bus_data_pin) && serial_clk |-> dev_data_oe_n[*8])
		else $error("slave pulls data after stop");
endmodule // two_wire_register_slave_assertions

// file: dv/two_wire_register_slave_tb_top.sv
// Bench: master and slave joined over the two-wire link
`timescale 1ns/1ps
module two_wire_register_slave_tb_top import two_wire_pkg::*;;
	localparam int         QTR      = 8;
	localparam logic [6:0] BAD_ADDR = 7'h22;
	logic              clk_i, link_clk_i, reset_n_i, reg_wr_o, reg_wr_b;
	logic              cmd_valid_i, cmd_valid_b, cmd_read_i, cmd_ready_o;
	logic              rsp_valid_o, rsp_nack_o, rsp_valid_b, rsp_nack_b;
	logic              cmd_ready_b, ack9, b_pulled;
	logic [PTR_W-1:0]  cmd_ptr_i, peek_addr_i, reg_waddr_o;
	logic [WORD_W-1:0] cmd_wdata_i, rsp_data_o, reg_wdata_o, peek_data_o;
	logic [WORD_W-1:0] exp_mem [256];
	logic [7:0]        sh, first_byte;
	logic [31:0]       lfsr_q;
	int                err_total, check_count, wr_cnt, nbit;

	tw_if bus_a ();
	tw_if bus_b ();
	two_wire_bus_master #(.QTR_CYCLES(QTR)) two_wire_bus_master_inst (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus_a),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
		.cmd_read_i(cmd_read_i), .cmd_ptr_i(cmd_ptr_i),
		.cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
		.rsp_data_o(rsp_data_o), .rsp_nack_o(rsp_nack_o));
	two_wire_register_slave two_wire_register_slave_inst (
		.link_clk_i(link_clk_i), .reset_n_i(reset_n_i), .bus(bus_a),
		.reg_wr_o(reg_wr_o), .reg_waddr_o(reg_waddr_o),
		.reg_wdata_o(reg_wdata_o), .peek_addr_i(peek_addr_i),
		.peek_data_o(peek_data_o));
	two_wire_bus_master #(.TARGET_ADDR(BAD_ADDR), .QTR_CYCLES(QTR))
	two_wire_bus_master_inst_b (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus_b),
		.cmd_valid_i(cmd_valid_b), .cmd_ready_o(cmd_ready_b),
		.cmd_read_i(cmd_read_i), .cmd_ptr_i(cmd_ptr_i),
		.cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_b),
		.rsp_data_o(), .rsp_nack_o(rsp_nack_b));
	two_wire_register_slave two_wire_register_slave_inst_b (
		.link_clk_i(link_clk_i), .reset_n_i(reset_n_i), .bus(bus_b),
		.reg_wr_o(reg_wr_b), .reg_waddr_o(), .reg_wdata_o(),
		.peek_addr_i(peek_addr_i), .peek_data_o());
	two_wire_register_slave_assertions #(.QTR_CYCLES(QTR))
	two_wire_register_slave_assertions_inst (
		.clk_i(clk_i), .link_clk_i(link_clk_i), .reset_n_i(reset_n_i),
		.serial_clk(bus_a.serial_clk), .host_data_out(bus_a.host_data_out),
		.host_data_oe_n(bus_a.host_data_oe_n),
		.dev_data_out(bus_a.dev_data_out),
		.dev_data_oe_n(bus_a.dev_data_oe_n),
		.serial_bus_data_pin(bus_a.serial_bus_data_pin));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#7;
		forever #15 link_clk_i = ~link_clk_i;
	end
	// Pulses last one link cycle, so look at the quiet edge
	always @(negedge link_clk_i) begin
		if (reg_wr_o === 1'b1) wr_cnt++;
		if (reg_wr_b === 1'b1 || bus_b.dev_data_oe_n === 1'b0) b_pulled = 1'b1;
	end
	always @(negedge bus_a.serial_bus_data_pin)
		if (bus_a.serial_clk === 1'b1) nbit = 0;
	always @(posedge bus_a.serial_clk) begin
		nbit++;
		if (nbit <= 8) sh = {sh[6:0], bus_a.serial_bus_data_pin};
		if (nbit == 8) first_byte = sh;
		if (nbit == 9) ack9 = bus_a.serial_bus_data_pin;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] addr_word(input logic rd);
		return {8'h00, DEV_ADDR_DEFAULT, rd};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Entered and left 1 ns after a clock edge
	task automatic run_cmd(input logic rd, input logic [7:0] p,
		input logic [15:0] d, input logic use_b);
		int n;
		cmd_read_i = rd;
		cmd_ptr_i = p;
		cmd_wdata_i = d;
		chk({15'h0, use_b ? cmd_ready_b : cmd_ready_o}, 16'h1);
		cmd_valid_i = !use_b;
		cmd_valid_b = use_b;
		@(posedge clk_i);
		#1;
		chk({15'h0, use_b ? cmd_ready_b : cmd_ready_o}, 16'h0);
		cmd_valid_i = 1'b0;
		cmd_valid_b = 1'b0;
		for (n = 0; n < 4000; n++) begin
			if ((use_b ? rsp_valid_b : rsp_valid_o) === 1'b1) break;
			@(posedge clk_i);
			#1;
		end
		chk({15'h0, n < 4000}, 16'h1);
	endtask
	task automatic do_write(input logic [7:0] p, input logic [15:0] d);
		int c0;
		c0 = wr_cnt;
		run_cmd(1'b0, p, d, 1'b0);
		exp_mem[p] = d;
		chk({15'h0, rsp_nack_o}, 16'h0);
		chk(16'(wr_cnt - c0), 16'h1);
		chk({8'h0, reg_waddr_o}, {8'h0, p});
		chk(reg_wdata_o, d);
		chk({8'h0, first_byte}, addr_word(DIR_WRITE));
		chk({15'h0, ack9}, 16'h0);
	endtask
	task automatic do_read(input logic [7:0] p);
		run_cmd(1'b1, p, 16'h0, 1'b0);
		chk(rsp_data_o, exp_mem[p]);
		chk({15'h0, rsp_nack_o}, 16'h0);
		chk({8'h0, first_byte}, addr_word(DIR_READ));
		chk({15'h0, ack9}, 16'h0);
		peek_addr_i = p;
		repeat (3) @(posedge link_clk_i);
		@(posedge clk_i);
		#1;
		chk(peek_data_o, exp_mem[p]);
	endtask
	task automatic do_reset();
		reset_n_i = 1'b0;
		foreach (exp_mem[i]) exp_mem[i] = REG_RESET;
		repeat (12) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		@(posedge clk_i);
		#1;
	endtask

	initial begin
		{cmd_valid_i, cmd_valid_b, cmd_read_i, b_pulled} = 4'h0;
		cmd_ptr_i = 8'h00;
		cmd_wdata_i = 16'h0000;
		peek_addr_i = 8'h00;
		lfsr_q = 32'h7DA0;
		do_reset();
		do_read(8'hFF);
		do_write(8'h00, 16'hFFFF);
		do_write(8'hFF, 16'h8001);
		do_read(8'h00);
		do_read(8'hFF);
		for (int i = 0; i < 10; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			do_write(lfsr_q[7:0], lfsr_q[23:8]);
			do_read(lfsr_q[7:0]);
			do_read(lfsr_q[15:8]);
		end
		do_write(8'h09, 16'h0284);
		run_cmd(1'b0, 8'h10, 16'hA5A5, 1'b1);
		chk({15'h0, rsp_nack_b}, 16'h1);
		chk({15'h0, b_pulled}, 16'h0);
		do_reset();
		do_read(8'h09);
		give_verdict();
	end
	// Normal run is near 53k cycles
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
endmodule // two_wire_register_slave_tb_top
